// File: pkg/lcdt_regs.vh
// register map, field positions and reset values of the lcd line timing block
`ifndef LCDT_REGS_VH
`define LCDT_REGS_VH
`define LCDT_ADDR_W        8
`define LCDT_OFF_CTRL0     8'h00
`define LCDT_OFF_LINE      8'h20
`define LCDT_OFF_STAT      8'h24
`define LCDT_OFF_POL       8'h30
`define LCDT_CTRL0_MASK    32'h000FF3BF
`define LCDT_LINE_MASK     32'hFFFFFFF0
`define LCDT_POL_MASK      32'h00000001
`define LCDT_CTRL0_RST     32'h00000000
`define LCDT_LINE_RST      32'h00000000
`define LCDT_POL_RST       32'h00000000
`define LCDT_B_EN          0
`define LCDT_B_MONO        1
`define LCDT_B_DUAL        2
`define LCDT_B_DTYPE       7
`define LCDT_B_BORD        8
`define LCDT_B_DPIX        9
`define LCDT_F_PDD_LO      12
`define LCDT_F_PDD_HI      19
`define LCDT_F_PPL_LO      4
`define LCDT_F_PPL_HI      9
`define LCDT_F_HSW_LO      10
`define LCDT_F_HSW_HI      15
`define LCDT_F_ELW_LO      16
`define LCDT_F_ELW_HI      23
`define LCDT_B_POL         0
`define LCDT_PPL_ADD       10'h00F
`define LCDT_ST_IDLE       2'h0
`define LCDT_ST_PIX        2'h1
`define LCDT_ST_EOL        2'h2
`define LCDT_ST_LCLK       2'h3
`endif

// File: hw/lcdt_top.v
// lcd mode control, palette request spacing and horizontal line timing
// Functional notes
// R01 - display type 0: passive panel, dither path enabled
// R02 - display type 1: no dither, continuous pixel clock, enable and syncs
// R03 - byte order 0: take halves, nibbles, bytes from the least significant end
// R04 - byte order 1: take halves, nibbles, bytes from the most significant end
// R05 - double pixel 0, single mono: four pixels per clock on low pins
// R06 - double pixel 1, single mono: eight pixels per clock on all pins
// R07 - double pixel bit ignored outside single-panel monochrome
// R08 - palette delay counts 0..255 memory clocks after last burst write
// R09 - palette requests masked while delay counter nonzero
// R10 - palette delay of zero never masks requests
// R11 - line length is ten-bit field plus 16 pixel clocks
// R12 - low four field bits not stored, read as zero
// R13 - pixel clock and data continue through whole programmed line
// R14 - line clock asserted after line and end wait elapsed
// R15 - pulse width loaded into six-bit down counter, negated at zero
// R16 - line clock lasts width plus one pixel clocks
// R17 - passive: pixel clock still during line pulse; active: toggles
// R18 - line clock level follows separate polarity setting
// R19 - end wait is eight-bit value plus one pixel clocks
// R20 - passive: pixel clock still during end wait; active: toggles
// R21 - software programs all fields before enabling, disables before changing
// R22 - reserved control bits ignore writes and read zero
// R23 - pixel count and end wait reloaded for every line
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`include "lcdt_regs.vh"
module lcdt_top (
	input  wire        clk,
	input  wire        rstn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        pclk_src,
	input  wire [31:0] fb_word,
	input  wire        fb_valid,
	output reg         fb_take,
	input  wire [31:0] pal_word,
	input  wire        pal_hi_sel,
	output reg  [15:0] pal_entry,
	input  wire        pal_req,
	input  wire        pal_burst_done,
	output reg         pal_req_out,
	output reg         pixel_clock_pin,
	output reg         line_clock_pin,
	output reg  [7:0]  panel_data_pins,
	output reg         data_enable_pin,
	output reg         dither_enable
);
	// control registers
	reg  [31:0] lcd_control_zero;
	reg  [31:0] lcd_line_timing_control;
	reg  [31:0] lcd_polarity_control;
	// bus data phase state
	reg         wr_pend;
	reg  [7:0]  wr_addr;
	// pixel clock sampling
	reg         pc_s1;
	reg         pc_s2;
	reg         pc_s3;
	reg         pc_lvl;
	// line timing
	reg  [1:0]  state;
	reg  [9:0]  pix_cnt;
	reg  [7:0]  eol_cnt;
	reg  [5:0]  hsw_cnt;
	reg  [31:0] shreg;
	reg  [2:0]  grp_left;
	// palette spacing
	reg  [7:0]  pdd_cnt;
	reg         mem_phase;
	// next values
	reg  [31:0] next_rdata;
	reg  [7:0]  next_data;
	reg  [31:0] next_shreg;

	wire        ctl_en     = lcd_control_zero[`LCDT_B_EN];
	wire        active     = lcd_control_zero[`LCDT_B_DTYPE];
	wire        big_end    = lcd_control_zero[`LCDT_B_BORD];
	wire        mono       = lcd_control_zero[`LCDT_B_MONO];
	wire        dual       = lcd_control_zero[`LCDT_B_DUAL];
	wire        dpix       = lcd_control_zero[`LCDT_B_DPIX];

	// timing and spacing fields, polarity from its own register
	wire [7:0]  palette_request_delay        = lcd_control_zero[`LCDT_F_PDD_HI:`LCDT_F_PDD_LO];
	wire [5:0]  ppl_hi     = lcd_line_timing_control[`LCDT_F_PPL_HI:`LCDT_F_PPL_LO];
	wire [5:0]  line_pulse_width        = lcd_line_timing_control[`LCDT_F_HSW_HI:`LCDT_F_HSW_LO];
	wire [7:0]  end_line_wait        = lcd_line_timing_control[`LCDT_F_ELW_HI:`LCDT_F_ELW_LO];
	wire        polarity   = lcd_polarity_control[`LCDT_B_POL];

	// bus transfer accepted at this edge
	wire        addr_phase = hsel & htrans[1] & hready;

	// single mono reads the double pixel bit, nowhere else; active ignores dual
	wire        narrow     = mono & ~(dual & ~active) & ~dpix; // R05 R07
	// nibble-wide mode empties a word in eight pixel clocks, byte-wide in four
	wire [2:0]  grp_last   = narrow ? 3'h7 : 3'h3;

	// a word is fetched and its first group shown on the same tick, so every
	// tick of the line carries a group and none is lost at a reload
	wire        grp_load   = (grp_left == 3'h0);
	wire [31:0] pix_src    = grp_load ? (fb_valid ? fb_word : 32'h00000000) : shreg;

	// pixel count load: field plus 16, minus one for the terminal tick
	wire [9:0]  ppl_load   = {ppl_hi, 4'h0} + `LCDT_PPL_ADD; // R11 R12

	// level filter: a change counts once the second and third stages agree
	wire        pc_agree   = (pc_s2 == pc_s3);
	wire        pix_tick   = pc_agree & pc_s3 & ~pc_lvl;

	// pixel clock visible in active mode always, in passive only for pixels
	wire        pclk_gate  = active | (state == `LCDT_ST_PIX); // R17 R20

	// read mux for the address phase; data go out registered
	always @* begin
		next_rdata = 32'h00000000;
		case (haddr[`LCDT_ADDR_W-1:0])
			`LCDT_OFF_CTRL0: next_rdata = lcd_control_zero;
			`LCDT_OFF_LINE:  next_rdata = lcd_line_timing_control;
			`LCDT_OFF_POL:   next_rdata = lcd_polarity_control;
			`LCDT_OFF_STAT:  next_rdata = {14'h0000, pdd_cnt, state,
				pix_cnt[9:2]};
			default:         next_rdata = 32'h00000000;
		endcase
	end

	// ahb-lite slave: zero wait states, always okay
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= addr_phase & hwrite;
			wr_addr   <= haddr[`LCDT_ADDR_W-1:0];
		end
	end

	// read data held until the next read, so a slow master still sees it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase & ~hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// register writes; masks drop reserved and unimplemented bits
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lcd_control_zero        <= `LCDT_CTRL0_RST;
			lcd_line_timing_control <= `LCDT_LINE_RST;
			lcd_polarity_control    <= `LCDT_POL_RST;
		end else if (wr_pend) begin
			case (wr_addr)
				`LCDT_OFF_CTRL0: lcd_control_zero <= hwdata & `LCDT_CTRL0_MASK; // R22
				`LCDT_OFF_LINE:  lcd_line_timing_control <=
					hwdata & `LCDT_LINE_MASK; // R12
				`LCDT_OFF_POL:   lcd_polarity_control <= hwdata & `LCDT_POL_MASK;
				default: ;
			endcase
		end
	end

	// pixel clock synchroniser, three stages then agreement filter
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_s1  <= 1'b0;
			pc_s2  <= 1'b0;
			pc_s3  <= 1'b0;
			pc_lvl <= 1'b0;
		end else begin
			pc_s1 <= pclk_src;
			pc_s2 <= pc_s1;
			pc_s3 <= pc_s2;
			if (pc_agree) begin
				pc_lvl <= pc_s3;
			end
		end
	end

	// pixel group picked by byte order, and what is left of the word
	// narrow mode drives only the low four pins; the high four stay zero
	always @* begin
		next_data  = 8'h00;
		next_shreg = 32'h00000000;
		if (narrow) begin
			next_data  = big_end ? {4'h0, pix_src[31:28]} : {4'h0, pix_src[3:0]}; // R03 R04 R05
			next_shreg = big_end ? {pix_src[27:0], 4'h0} : {4'h0, pix_src[31:4]};
		end else begin
			next_data  = big_end ? pix_src[31:24] : pix_src[7:0]; // R03 R04 R06
			next_shreg = big_end ? {pix_src[23:0], 8'h00} : {8'h00, pix_src[31:8]};
		end
	end

	// pixel data path, one group per pixel clock tick while the line runs
	// pins rest at zero in the wait and pulse phases and while disabled
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shreg           <= 32'h00000000;
			grp_left        <= 3'h0;
			fb_take         <= 1'b0;
			panel_data_pins <= 8'h00;
		end else begin
			fb_take <= 1'b0;
			if (!ctl_en) begin
				grp_left        <= 3'h0;
				panel_data_pins <= 8'h00;
			end else if (pix_tick) begin
				if (state == `LCDT_ST_PIX) begin
					// underrun pads with zero; padding pixels still go out
					panel_data_pins <= next_data; // R05 R06 R13
					shreg           <= next_shreg;
					if (grp_load) begin
						fb_take  <= fb_valid;
						grp_left <= grp_last;
					end else begin
						grp_left <= grp_left - 3'h1;
					end
				end else begin
					// a new line always starts on a fresh word
					grp_left        <= 3'h0;
					panel_data_pins <= 8'h00;
				end
			end
		end
	end

	// horizontal timing, one step per rising edge of the pixel clock
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state           <= `LCDT_ST_IDLE;
			pix_cnt         <= 10'h000;
			eol_cnt         <= 8'h00;
			hsw_cnt         <= 6'h00;
			line_clock_pin  <= 1'b0;
			data_enable_pin <= 1'b0;
		end else begin
			line_clock_pin <= (state == `LCDT_ST_LCLK) ^ polarity; // R18
			data_enable_pin <= active & (state == `LCDT_ST_PIX); // R02
			if (!ctl_en) begin
				state    <= `LCDT_ST_IDLE;
			end else if (pix_tick) begin
				case (state)
					`LCDT_ST_IDLE: begin
						// first tick after enable opens the line
						state   <= `LCDT_ST_PIX;
						pix_cnt <= ppl_load;
					end
					`LCDT_ST_PIX: begin
						// data groups go out from their own process on this tick
						if (pix_cnt == 10'h000) begin
							state   <= `LCDT_ST_EOL; // R13
							eol_cnt <= end_line_wait; // R19 R23
						end else begin
							pix_cnt <= pix_cnt - 10'h001; // R11 R13
						end
					end
					`LCDT_ST_EOL: begin
						// dummy ticks before the line pulse
						if (eol_cnt == 8'h00) begin
							state   <= `LCDT_ST_LCLK; // R14
							hsw_cnt <= line_pulse_width; // R15
						end else begin
							eol_cnt <= eol_cnt - 8'h01; // R19
						end
					end
					`LCDT_ST_LCLK: begin
						// pulse ends at zero, next line follows at once
						if (hsw_cnt == 6'h00) begin
							state   <= `LCDT_ST_PIX; // R15 R16
							pix_cnt <= ppl_load; // R23
						end else begin
							hsw_cnt <= hsw_cnt - 6'h01; // R15
						end
					end
					default: state <= `LCDT_ST_IDLE;
				endcase
			end
		end
	end

	// gated pixel clock pin; passive panels see it still outside pixels
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pixel_clock_pin <= 1'b0;
		end else begin
			pixel_clock_pin <= ctl_en & pclk_gate & pc_lvl; // R17 R20
		end
	end

	// dither flag, only a mode indication for the pixel path
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dither_enable <= 1'b0;
		end else begin
			dither_enable <= ctl_en & ~active; // R01 R02
		end
	end

	// palette half-word unpack by byte order
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pal_entry <= 16'h0000;
		end else begin
			pal_entry <= (pal_hi_sel ^ big_end) ? pal_word[31:16] : pal_word[15:0]; // R03 R04
		end
	end

	// palette request spacing; memory clock is every second cycle of clk
	// a burst end reloads the count even when a decrement falls with it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pdd_cnt   <= 8'h00;
			mem_phase <= 1'b0;
		end else begin
			mem_phase <= ~mem_phase;
			if (pal_burst_done) begin
				pdd_cnt   <= palette_request_delay; // R08 R10
				mem_phase <= 1'b0;
			end else if (mem_phase & (pdd_cnt != 8'h00)) begin
				pdd_cnt <= pdd_cnt - 8'h01; // R08
			end
		end
	end

	// outgoing request; a zero delay never masks, not even on the burst end
	// a request held by the requester issues once the count is zero
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pal_req_out <= 1'b0;
		end else if (pal_burst_done) begin
			pal_req_out <= pal_req & (palette_request_delay == 8'h00); // R09 R10
		end else begin
			pal_req_out <= pal_req & (pdd_cnt == 8'h00); // R09
		end
	end
endmodule

// File: bench/lcdt_assertions.sv
// port-level property checks for the lcd line timing block
module lcdt_assertions (
	input wire        clk,
	input wire        rstn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        pal_req,
	input wire        pal_burst_done,
	input wire        pal_req_out,
	input wire        pixel_clock_pin,
	input wire        line_clock_pin,
	input wire        data_enable_pin,
	input wire [7:0]  panel_data_pins,
	input wire        dither_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        a_wr, a_ru, sh_pol;
	logic [7:0]  a_ad;
	logic [31:0] sh_c0;
	wire         lact = line_clock_pin ^ sh_pol;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// shadow the control writes, so mode checks need no internal probes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			a_wr <= 1'b0;
			a_ru <= 1'b0;
			a_ad <= 8'h00;
			sh_c0 <= 32'h00000000;
			sh_pol <= 1'b0;
		end else begin
			a_wr <= hsel & htrans[1] & hready & hwrite;
			a_ru <= hsel & htrans[1] & hready & !hwrite & (haddr[7:0] == 8'h10);
			a_ad <= haddr[7:0];
			if (a_wr && a_ad == 8'h00)
				sh_c0 <= hwdata;
			if (a_wr && a_ad == 8'h30)
				sh_pol <= hwdata[0];
		end
	end
	chk_ready_always: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("error response");
	chk_rd_unmapped: assert property (a_ru |-> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_dither_mode: assert property ($past(sh_c0) == sh_c0
		|-> dither_enable == (sh_c0[0] & !sh_c0[7])) else $error("dither flag wrong");
	chk_den_passive: assert property (!sh_c0[7] && $past(!sh_c0[7]) |-> !data_enable_pin)
		else $error("enable pin in passive mode");
	chk_pix_still: assert property (dither_enable && $past(dither_enable) && lact
		&& $past(lact) |-> $stable(pixel_clock_pin)) else $error("pixel clock moved in pulse");
	chk_lclk_width: assert property ($rose(lact) && sh_c0[0] && $stable(sh_pol)
		|=> (lact || !sh_c0[0])[*8]) else $error("line pulse too short");
	chk_pal_gated: assert property (pal_req_out |-> $past(pal_req))
		else $error("request without cause");
	chk_pal_mask: assert property ($rose(pal_burst_done) && sh_c0[19:14] != 6'h00
		|-> ##3 (!pal_req_out)[*3]) else $error("request not masked");
	chk_pal_open: assert property (sh_c0[19:12] == 8'h00 && $past(sh_c0[19:12]) == 8'h00
		|-> pal_req_out == $past(pal_req)) else $error("request masked at zero delay");
	chk_data_pulse: assert property (lact && sh_c0[0] |-> panel_data_pins == 8'h00)
		else $error("data pins busy during line pulse");
endmodule
bind lcdt_top lcdt_assertions i_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pal_req(pal_req), .pal_burst_done(pal_burst_done),
	.pal_req_out(pal_req_out), .pixel_clock_pin(pixel_clock_pin),
	.line_clock_pin(line_clock_pin), .data_enable_pin(data_enable_pin),
	.panel_data_pins(panel_data_pins),
	.dither_enable(dither_enable));

// File: bench/lcdt_panel_model.sv
// panel stand-in: pixel clock source, frame words, line timing measurement
module lcdt_panel_model (
	input  wire         clk,
	input  wire         pol,
	input  wire         pixel_clock_pin,
	input  wire         line_clock_pin,
	input  wire         fb_take,
	output logic        pclk_src,
	output logic [31:0] fb_word,
	output logic        fb_valid,
	output int          line_cnt,
	output int          pix_per_line,
	output int          pulse_w
);
	timeunit 1ns;
	timeprecision 1ps;
	int   pix, w;
	logic p_q, l_q, s_q;
	wire  lact = line_clock_pin ^ pol;
	// free-running source, phase unrelated to clk
	initial begin
		{pclk_src, p_q, l_q, s_q} = 4'h0;
		{pix, w, line_cnt, pix_per_line, pulse_w} = '0;
		fb_word = 32'h00000000;
		fb_valid = 1'b1;
		#13;
		forever #32 pclk_src = ~pclk_src;
	end
	// sampled in clk domain so coincident edges never race
	always @(posedge clk) begin
		if (fb_take)
			fb_word <= fb_word + 32'h11111111;
		if (pixel_clock_pin && !p_q)
			pix++;
		if (lact && pclk_src && !s_q)
			w++;
		if (lact && !l_q) begin
			pix_per_line = pix;
			pix = 0;
			line_cnt++;
		end
		if (!lact && l_q) begin
			pulse_w = w;
			w = 0;
		end
		{p_q, l_q, s_q} = {pixel_clock_pin, lact, pclk_src};
	end
endmodule

// File: bench/lcdt_top_tb_top.sv
// self-checking bench for the lcd line timing block
module lcdt_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, hsel, hwrite, pal_hi_sel, pal_req, pal_burst_done, polr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, pal_word, q;
	wire  [31:0] hrdata, fb_word;
	wire  [15:0] pal_entry;
	wire  [7:0]  panel_data_pins;
	wire         hreadyout, hresp, pclk_src, fb_valid, fb_take, pal_req_out;
	wire         pixel_clock_pin, line_clock_pin, data_enable_pin, dither_enable;
	int          n_errors, cmp_count, line_cnt, pix_per_line, pulse_w;
	lcdt_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pclk_src(pclk_src),
		.fb_word(fb_word), .fb_valid(fb_valid), .fb_take(fb_take), .pal_word(pal_word),
		.pal_hi_sel(pal_hi_sel), .pal_entry(pal_entry), .pal_req(pal_req),
		.pal_burst_done(pal_burst_done), .pal_req_out(pal_req_out),
		.pixel_clock_pin(pixel_clock_pin), .line_clock_pin(line_clock_pin),
		.panel_data_pins(panel_data_pins), .data_enable_pin(data_enable_pin),
		.dither_enable(dither_enable));
	lcdt_panel_model i_panel (.clk(clk), .pol(polr), .pixel_clock_pin(pixel_clock_pin),
		.line_clock_pin(line_clock_pin), .fb_take(fb_take), .pclk_src(pclk_src),
		.fb_word(fb_word), .fb_valid(fb_valid), .line_cnt(line_cnt),
		.pix_per_line(pix_per_line), .pulse_w(pulse_w));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one single transfer; waits on ready, no fixed latency assumed
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// idle cycle between: a read right after a write sees the old value
	task automatic wrd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
		bus(1'b1, a, d);
		@(posedge clk);
		bus(1'b0, a, 32'h00000000);
		chk(q, e);
	endtask
	task automatic wait_lines(input int k);
		int n;
		n = line_cnt + k;
		for (int i = 0; i < 20000 && line_cnt < n; i++)
			@(posedge clk);
	endtask
	task automatic stop_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog well past the few thousand cycles the sequence needs
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		$display("mismatch at %0t: timeout", $time);
		stop_test();
	end
	initial begin
		{rstn, hsel, hwrite, pal_hi_sel, pal_req, pal_burst_done, polr} = 7'h00;
		{htrans, hsize, haddr, hwdata, pal_word} = {2'h0, 3'h2, 32'h0, 32'h0, 32'h12345678};
		{n_errors, cmp_count} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wrd(32'h20, 32'hFFFFFFFF, 32'hFFFFFFF0);
		wrd(32'h00, 32'hFFFFFFFF, 32'h000FF3BF);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		wrd(32'h10, 32'hFFFFFFFF, 32'h00000000);
		wrd(32'h00, 32'h00000100, 32'h00000100);
		repeat (2) @(posedge clk);
		chk({16'h0000, pal_entry}, 32'h00001234);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		repeat (2) @(posedge clk);
		chk({16'h0000, pal_entry}, 32'h00005678);
		wrd(32'h20, 32'h00020C10, 32'h00020C10);
		wrd(32'h00, 32'h00000001, 32'h00000001);
		wait_lines(3);
		chk(pix_per_line, 32);
		chk(pulse_w, 4);
		chk({31'h0, dither_enable}, 32'h1);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		wrd(32'h00, 32'h00000081, 32'h00000081);
		wait_lines(3);
		chk(pix_per_line, 39);
		chk(pulse_w, 4);
		chk({31'h0, dither_enable}, 32'h0);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		wrd(32'h30, 32'h00000001, 32'h00000001);
		polr <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, line_clock_pin}, 32'h1);
		wrd(32'h00, 32'h00000001, 32'h00000001);
		wait_lines(3);
		chk(pulse_w, 4);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		pal_req <= 1'b1;
		wrd(32'h00, 32'h00005000, 32'h00005000);
		repeat (3) @(posedge clk);
		chk({31'h0, pal_req_out}, 32'h1);
		pal_burst_done <= 1'b1;
		@(posedge clk);
		pal_burst_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, pal_req_out}, 32'h0);
		repeat (20) @(posedge clk);
		chk({31'h0, pal_req_out}, 32'h1);
		wrd(32'h00, 32'h00000000, 32'h00000000);
		pal_burst_done <= 1'b1;
		@(posedge clk);
		pal_burst_done <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, pal_req_out}, 32'h1);
		stop_test();
	end
endmodule
